// [gcir_top.sv]
// Global configuration and interrupt register block of a four-channel serial device
//
// Summary of operation
// - Decode 256 addresses, four 16-byte channel blocks
// - Channel first eight locations are classic registers
// - Global registers live at 0x80 to 0x8F
// - Global registers reached directly, no unlock
// - Pending bit n follows channel n, bit 0 also timer and wake; bits 7:4 zero
// - Pending clears by channel status reads; timer by timer command read, wake by sleep or channel 0 read
// - Three-bit codes packed over two locator registers; third locator reads zero
// - Timer code 7 only on channel 0
// - Pending and locators reset to zero
// - Timer and wake masked by own registers
// - Wake interrupt only if all four slept
// - Self-clearing channel reset and broadcast writes
// - Per-channel 8X or 16X sampling select bits
// - Read-only identity and revision registers
// - Source code meanings, 5 and 6 reserved
// - Reset bits clear themselves after reset
// - Timer command read clears timer pending
// - 8X sampling doubles channel data rates
`timescale 1ns/1ps
module gcir_top (
   // Clock and reset
   input  wire logic                      CLOCK,
   input  wire logic                      RST_N,
   // Host register port, same clock domain
   input  wire gcir_pkg::gcir_bus_t       BUS,
   output logic [7:0]                     RDATA,
   // Channel logic side
   input  wire gcir_pkg::gcir_chan_t [3:0] CH_REPORT,
   input  wire logic [7:0]                CH_RDATA [4],
   output gcir_pkg::gcir_chacc_t [3:0]    CH_ACC,
   output logic [3:0]                     CH_SOFT_RESET,
   output logic [3:0]                     CH_SAMPLE_8X,
   output logic [3:0]                     CH_SLEEP_EN,
   // Timer and wake events, one-cycle pulses
   input  wire logic                      TIMER_TIMEOUT,
   input  wire logic                      WAKE_EVENT,
   output logic [3:0]                     TIMER_CMD,
   output logic                           TIMER_CMD_STB,
   output logic [15:0]                    TIMER_COUNT,
   // Combined interrupt request, active high
   output logic                           IRQ
);
   import gcir_pkg::*;

   // Address decode
   wire        in_chan    = (BUS.addr <= ADDR_CH_LAST);
   wire        in_global  = (BUS.addr >= ADDR_GLOBAL_BASE) &&
                            (BUS.addr <= ADDR_GLOBAL_LAST);
   wire [1:0]  ch_sel     = BUS.addr[CH_SLOT_LSB+1:CH_SLOT_LSB];
   wire [3:0]  ch_idx     = BUS.addr[3:0];
   wire        g_wr       = BUS.wr && in_global;
   wire        g_rd       = BUS.rd && in_global;

   // Global state
   logic [3:0] sample_8x;     // 1 = 8X sampling
   logic [3:0] sleep_en;      // Per-channel sleep enables
   logic       bcast;         // Broadcast channel writes
   logic [3:0] soft_rst;      // Self-clearing channel resets
   logic [7:0] timer_low;     // Timer reload, low byte
   logic [7:0] timer_high;    // Timer reload, high byte
   logic       timer_irq_en;  // Timer interrupt enable
   logic       timer_pend;    // Timer time-out pending
   logic       wake_pend;     // Wake-up interrupt pending
   logic       all_slept;     // All four channels were asleep
   logic [3:0] pend_map;      // Registered pending bitmap
   logic [2:0] src_code [4];  // Registered source codes

   // Write decode
   function automatic logic hit(input logic [7:0] ofs);
      hit = g_wr && (BUS.addr == ofs);
   endfunction

   wire rd_timer_cmd = g_rd && (BUS.addr == OFS_TIMER_CMD);
   wire rd_sleep     = g_rd && (BUS.addr == OFS_SLEEP_EN);

   // Channel access routing; broadcast copies writes to every channel
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         wire sel_me = in_chan && (ch_sel == 2'(g));
         assign CH_ACC[g].rd      = BUS.rd && sel_me;
         assign CH_ACC[g].wr      = BUS.wr && in_chan && (sel_me || bcast);
         assign CH_ACC[g].reg_idx = ch_idx;
         assign CH_ACC[g].wdata   = BUS.wdata;
      end
   endgenerate

   // Pending and source codes; channel logic clears its own irq on
   // status reads, so global reads cannot disturb it
   logic [3:0] next_pend;
   logic [2:0] next_code [4];
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         next_pend[i] = CH_REPORT[i].irq;
         next_code[i] = CH_REPORT[i].irq ? CH_REPORT[i].code : SRC_NONE;
         if (next_code[i] == SRC_TIMER) begin
            next_code[i] = SRC_NONE;
         end
      end
      // Timer reports as channel 0; channel source wins by priority
      if (timer_pend && timer_irq_en && !CH_REPORT[0].irq) begin
         next_pend[0] = 1'b1;
         next_code[0] = SRC_TIMER;
      end
      // Wake-up shows as pending with code none on channel 0
      if (wake_pend && !next_pend[0]) begin
         next_pend[0] = 1'b1;
      end
   end

   // Source locator packing, 3 bits per channel
   wire [23:0] packed_codes = {12'h000, src_code[3], src_code[2],
                               src_code[1], src_code[0]};

   // Status registers
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         pend_map <= 4'h0;
         for (int i = 0; i < NUM_CH; i++) src_code[i] <= SRC_NONE;
      end else begin
         pend_map <= next_pend;
         for (int i = 0; i < NUM_CH; i++) src_code[i] <= next_code[i];
      end
   end

   // Timer pending: set wins over the clearing read
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         timer_pend <= 1'b0;
      end else if (TIMER_TIMEOUT) begin
         timer_pend <= 1'b1;
      end else if (rd_timer_cmd) begin
         timer_pend <= 1'b0;
      end
   end

   // Timer interrupt enable from commands
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         timer_irq_en <= 1'b0;
      end else if (hit(OFS_TIMER_CMD) && BUS.wdata[3:0] == TCMD_IRQ_ON) begin
         timer_irq_en <= 1'b1;
      end else if (hit(OFS_TIMER_CMD) && BUS.wdata[3:0] == TCMD_IRQ_OFF) begin
         timer_irq_en <= 1'b0;
      end
   end

   // Sleep tracking and wake interrupt; sleep register is the wake mask
   wire all_asleep = (sleep_en == 4'hF);
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         all_slept <= 1'b0;
         wake_pend <= 1'b0;
      end else begin
         all_slept <= all_asleep;
         if (WAKE_EVENT && all_slept && all_asleep) begin
            wake_pend <= 1'b1;
         end else if (rd_sleep || CH_ACC[0].rd) begin
            wake_pend <= 1'b0;
         end
      end
   end

   // Control registers
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         sample_8x  <= 4'h0;
         sleep_en   <= 4'h0;
         bcast      <= 1'b0;
         timer_low  <= RST_ZERO;
         timer_high <= RST_ZERO;
      end else begin
         if (hit(OFS_SAMPLE_RATE)) sample_8x  <= BUS.wdata[3:0];
         if (hit(OFS_SLEEP_EN))    sleep_en   <= BUS.wdata[3:0];
         if (hit(OFS_BROADCAST))   bcast      <= BUS.wdata[BCAST_BIT];
         if (hit(OFS_TIMER_LOW))   timer_low  <= BUS.wdata;
         if (hit(OFS_TIMER_HIGH))  timer_high <= BUS.wdata;
      end
   end

   // Soft reset: one-cycle pulse per written one, then self-clears
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         soft_rst <= 4'h0;
      end else if (hit(OFS_SOFT_RESET)) begin
         soft_rst <= BUS.wdata[3:0];
      end else begin
         soft_rst <= 4'h0;
      end
   end

   // Read mux, combinational; unmapped and reserved give zero
   logic [7:0] g_rdata;
   always_comb begin
      case (BUS.addr)
         OFS_PENDING_MAP: g_rdata = {4'h0, pend_map};
         OFS_SRC_LOW:     g_rdata = packed_codes[7:0];
         OFS_SRC_MID:     g_rdata = packed_codes[15:8];
         OFS_SRC_HIGH:    g_rdata = packed_codes[23:16];
         OFS_TIMER_CMD:   g_rdata = timer_pend ? TIMER_PEND_READ : RST_ZERO;
         OFS_TIMER_LOW:   g_rdata = timer_low;
         OFS_TIMER_HIGH:  g_rdata = timer_high;
         OFS_SAMPLE_RATE: g_rdata = {4'h0, sample_8x};
         OFS_SLEEP_EN:    g_rdata = {4'h0, sleep_en};
         OFS_REVISION:    g_rdata = REVISION_CODE;
         OFS_IDENTITY:    g_rdata = IDENTITY_CODE;
         OFS_BROADCAST:   g_rdata = {7'h00, bcast};
         default:         g_rdata = RST_ZERO;
      endcase
   end

   // Final read data: channel, global or zero
   always_comb begin
      if (in_chan)        RDATA = CH_RDATA[ch_sel];
      else if (in_global) RDATA = g_rdata;
      else                RDATA = RST_ZERO;
   end

   // Outputs
   assign CH_SOFT_RESET = soft_rst;
   assign CH_SAMPLE_8X  = sample_8x;
   assign CH_SLEEP_EN   = sleep_en;
   assign TIMER_CMD     = BUS.wdata[3:0];
   assign TIMER_CMD_STB = hit(OFS_TIMER_CMD);
   assign TIMER_COUNT   = {timer_high, timer_low};
   assign IRQ           = |pend_map;

   // Assertions
   AST_PEND_HIGH_ZERO: assert property (@(posedge CLOCK) disable iff (!RST_N)
      BUS.rd && BUS.addr == OFS_PENDING_MAP |-> RDATA[7:4] == 4'h0)
      else $error("pending map upper bits not zero");
   AST_PEND_FOLLOWS: assert property (@(posedge CLOCK) disable iff (!RST_N)
      CH_REPORT[1].irq |=> pend_map[1])
      else $error("pending bit did not follow channel");
   AST_CODE7_CH0: assert property (@(posedge CLOCK) disable iff (!RST_N)
      src_code[1] != SRC_TIMER && src_code[2] != SRC_TIMER && src_code[3] != SRC_TIMER)
      else $error("timer code on non-zero channel");
   AST_TIMER_CLEAR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      rd_timer_cmd && !TIMER_TIMEOUT |=> !timer_pend)
      else $error("timer pending not cleared by read");
   AST_TIMER_READ: assert property (@(posedge CLOCK) disable iff (!RST_N)
      BUS.rd && BUS.addr == OFS_TIMER_CMD |-> RDATA == {7'h00, timer_pend})
      else $error("timer command read value wrong");
   // Back-to-back reset writes are legal, so only a lone write is timed
   AST_RESET_PULSE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      hit(OFS_SOFT_RESET) ##1 !hit(OFS_SOFT_RESET)
         |-> soft_rst == $past(BUS.wdata[3:0]) ##1 soft_rst == 4'h0)
      else $error("soft reset not one-cycle");
   AST_BCAST_WR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      bcast && BUS.wr && in_chan |-> (CH_ACC[0].wr && CH_ACC[3].wr))
      else $error("broadcast write missed a channel");
   AST_RSVD_ZERO: assert property (@(posedge CLOCK) disable iff (!RST_N)
      BUS.rd && BUS.addr > ADDR_CH_LAST && BUS.addr < ADDR_GLOBAL_BASE
         |-> RDATA == RST_ZERO)
      else $error("reserved read not zero");
   AST_WAKE_GATE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      $rose(wake_pend) |-> $past(all_slept))
      else $error("wake interrupt without all channels asleep");
   AST_IDENT: assert property (@(posedge CLOCK) disable iff (!RST_N)
      BUS.rd && BUS.addr == OFS_IDENTITY |-> RDATA == IDENTITY_CODE)
      else $error("identity read wrong");

   COV_TIMER_IRQ: cover property (@(posedge CLOCK) disable iff (!RST_N)
      src_code[0] == SRC_TIMER ##[1:20] rd_timer_cmd);
   COV_SOFT_RESET: cover property (@(posedge CLOCK) disable iff (!RST_N) soft_rst != 4'h0);
   COV_BCAST: cover property (@(posedge CLOCK) disable iff (!RST_N) bcast && BUS.wr && in_chan);
   COV_WAKE: cover property (@(posedge CLOCK) disable iff (!RST_N) $rose(wake_pend));
endmodule

// [gcir_pkg.sv]
// Package: global register map, fields, reset values and types of the global block
package gcir_pkg;
   // Address map
   localparam logic [7:0] ADDR_CH_LAST     = 8'h3F;  // End of channel blocks
   localparam logic [7:0] ADDR_GLOBAL_BASE = 8'h80;  // Start of global block
   localparam logic [7:0] ADDR_GLOBAL_LAST = 8'h8F;  // End of global block
   localparam int         CH_SLOT_LSB      = 4;      // Channel number at addr[5:4]
   localparam logic [3:0] CH_STD_LAST      = 4'h7;   // Last classic register index
   // Global register offsets
   localparam logic [7:0] OFS_PENDING_MAP  = 8'h80;
   localparam logic [7:0] OFS_SRC_LOW      = 8'h81;
   localparam logic [7:0] OFS_SRC_MID      = 8'h82;
   localparam logic [7:0] OFS_SRC_HIGH     = 8'h83;
   localparam logic [7:0] OFS_TIMER_CMD    = 8'h84;
   localparam logic [7:0] OFS_TIMER_SPARE  = 8'h85;
   localparam logic [7:0] OFS_TIMER_LOW    = 8'h86;
   localparam logic [7:0] OFS_TIMER_HIGH   = 8'h87;
   localparam logic [7:0] OFS_SAMPLE_RATE  = 8'h88;
   localparam logic [7:0] OFS_SPARE_A      = 8'h89;
   localparam logic [7:0] OFS_SOFT_RESET   = 8'h8A;
   localparam logic [7:0] OFS_SLEEP_EN     = 8'h8B;
   localparam logic [7:0] OFS_REVISION     = 8'h8C;
   localparam logic [7:0] OFS_IDENTITY     = 8'h8D;
   localparam logic [7:0] OFS_BROADCAST    = 8'h8E;
   // Reset values
   localparam logic [7:0] RST_ZERO         = 8'h00;
   localparam logic [7:0] TIMER_PEND_READ  = 8'h01;  // Timer command read while pending
   // Arbitrary identity values, not tied to any real part
   localparam logic [7:0] IDENTITY_CODE    = 8'h5A;
   localparam logic [7:0] REVISION_CODE    = 8'h01;
   // Fields
   localparam int         BCAST_BIT        = 0;
   localparam int         NUM_CH           = 4;
   // Source codes
   localparam logic [2:0] SRC_NONE         = 3'h0;
   localparam logic [2:0] SRC_RX_LINE      = 3'h1;
   localparam logic [2:0] SRC_RX_TIMEOUT   = 3'h2;
   localparam logic [2:0] SRC_TX_EMPTY     = 3'h3;
   localparam logic [2:0] SRC_MODEM        = 3'h4;
   localparam logic [2:0] SRC_TIMER        = 3'h7;
   // Timer commands
   localparam logic [3:0] TCMD_IRQ_ON      = 4'h1;
   localparam logic [3:0] TCMD_IRQ_OFF     = 4'h2;

   // Host access
   typedef struct packed {
      logic       rd;     // Read strobe, one cycle
      logic       wr;     // Write strobe, one cycle
      logic [7:0] addr;   // Byte address
      logic [7:0] wdata;  // Write data
   } gcir_bus_t;

   // Per-channel report from the channel logic
   typedef struct packed {
      logic       irq;    // Channel requests service (already enable-gated)
      logic [2:0] code;   // Highest-priority source code
   } gcir_chan_t;

   // Access strobe routed to a channel block
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [3:0] reg_idx;
      logic [7:0] wdata;
   } gcir_chacc_t;
endpackage

// [gcir_host.sv]
// Host processor model that drives the global register port
`timescale 1ns/1ps
module gcir_host (
   // Clock
   input  wire logic          CLOCK,
   // Register port
   output gcir_pkg::gcir_bus_t BUS,
   input  wire logic [7:0]    RDATA
);
   import gcir_pkg::*;
   // Idle bus at time zero, before reset is released
   initial BUS = '0;
   // One access: strobe for one cycle, read data taken at the edge that takes it
   // Released address and data are inverted so stale values never look valid
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge CLOCK);
      BUS <= '{rd: !w, wr: w, addr: a, wdata: d};
      @(posedge CLOCK);
      q = RDATA;
      BUS <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule

// [global_config_and_interrupt_regs_tb.sv]
// Self-checking bench of the global configuration and interrupt block
`timescale 1ns/1ps
module global_config_and_interrupt_regs_tb;
   import gcir_pkg::*;
   logic             clock, rst_n, timer_timeout, wake_event, timer_cmd_stb, irq;
   gcir_bus_t        bus;
   logic [7:0]       rdata, q, a;
   gcir_chan_t [3:0] ch_report;
   gcir_chan_t       rep;
   logic [7:0]       ch_rdata [4];
   gcir_chacc_t [3:0] ch_acc;
   logic [3:0]       ch_soft_reset, ch_sample_8x, ch_sleep_en, timer_cmd;
   logic [15:0]      timer_count;
   int               n_fail, cmp_count, seed, i, c, r, exp_map, exp_src, bcast;
   // Addresses that must read zero after reset, reserved ones included
   logic [7:0] zero_tab [11] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
                                 8'h89, 8'h40, 8'h7F, 8'h90, 8'hFF};
   // Device under test and host model
   gcir_top i_dut (.CLOCK(clock), .RST_N(rst_n), .BUS(bus), .RDATA(rdata),
      .CH_REPORT(ch_report), .CH_RDATA(ch_rdata), .CH_ACC(ch_acc),
      .CH_SOFT_RESET(ch_soft_reset), .CH_SAMPLE_8X(ch_sample_8x),
      .CH_SLEEP_EN(ch_sleep_en), .TIMER_TIMEOUT(timer_timeout),
      .WAKE_EVENT(wake_event), .TIMER_CMD(timer_cmd),
      .TIMER_CMD_STB(timer_cmd_stb), .TIMER_COUNT(timer_count), .IRQ(irq));
   gcir_host i_host (.CLOCK(clock), .BUS(bus), .RDATA(rdata));
   // Verdict, the single place where the run ends
   task automatic tally_and_finish;
      if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Compare of register read data
   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t read %h expected %h", $time, got, exp);
      end
   endtask
   // Compare of a port output
   task automatic cmp_port(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t port %h expected %h", $time, got, exp);
      end
   endtask
   // Bus read with check, and plain bus write
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      logic [7:0] d;
      i_host.xfer(1'b0, ad, 8'h00, d);
      cmp_rd(d, e);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      logic [7:0] d2;
      i_host.xfer(1'b1, ad, d, d2);
   endtask
   // One-cycle event pulse, timer when t is set, wake otherwise
   task automatic pulse(input logic t);
      @(posedge clock);
      if (t) timer_timeout <= 1'b1;
      else wake_event <= 1'b1;
      @(posedge clock);
      timer_timeout <= 1'b0;
      wake_event <= 1'b0;
   endtask
   // Free-running clock, 10 ns period
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Hang guard, far beyond the expected run length
   initial begin
      #300000;
      n_fail++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      seed = 32'hA8702AD3;
      rst_n = 1'b0;
      timer_timeout = 1'b0;
      wake_event = 1'b0;
      ch_report = '0;
      bcast = 0;
      for (i = 0; i < 4; i++) ch_rdata[i] = 8'h00;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      // Reset values and reserved space
      for (i = 0; i < 11; i++) rd(zero_tab[i], RST_ZERO);
      rd(OFS_IDENTITY, IDENTITY_CODE);
      rd(OFS_REVISION, REVISION_CODE);
      // Writes to read-only and reserved places change nothing
      for (i = 5; i < 11; i++) wr(zero_tab[i], 8'hFF);
      wr(OFS_IDENTITY, 8'hFF);
      rd(OFS_TIMER_SPARE, RST_ZERO);
      rd(OFS_SPARE_A, RST_ZERO);
      rd(OFS_IDENTITY, IDENTITY_CODE);
      // Random channel reports, packing, channel reads and writes
      for (i = 0; i < 16; i++) begin
         exp_map = 0;
         exp_src = 0;
         if (i == 8) wr(OFS_BROADCAST, 8'h01);
         bcast = (i >= 8);
         @(posedge clock);
         for (c = 0; c < 4; c++) begin
            r = {$random(seed)} % 10;
            rep.irq = 1'(r % 2);
            rep.code = rep.irq ? 3'(r / 2) : SRC_NONE;
            ch_report[c] <= rep;
            ch_rdata[c] <= 8'($random(seed));
            exp_map |= int'(rep.irq) << c;
            exp_src |= int'(rep.code) << (3 * c);
         end
         rd(OFS_PENDING_MAP, 8'(exp_map));
         rd(OFS_SRC_LOW, 8'(exp_src));
         rd(OFS_SRC_MID, 8'(exp_src >> 8));
         rd(OFS_SRC_HIGH, RST_ZERO);
         rd(OFS_PENDING_MAP, 8'(exp_map));
         cmp_port(16'(irq), 16'(exp_map != 0));
         a = 8'(16 * (i % 4) + i % 8);
         // Channel reads go only to the addressed channel, broadcast or not
         fork
            rd(a, ch_rdata[i % 4]);
            begin
               @(posedge clock);
               @(negedge clock);
               for (c = 0; c < 4; c++) begin
                  cmp_port(16'(ch_acc[c].rd), 16'(c == i % 4));
               end
            end
         join
         a = 8'(16 * ((i + 1) % 4) + i % 16);
         fork
            wr(a, 8'(i));
            begin
               @(posedge clock);
               @(negedge clock);
               for (c = 0; c < 4; c++) begin
                  cmp_port(16'(ch_acc[c].wr), 16'(bcast || c == (i + 1) % 4));
                  cmp_port({ch_acc[c].reg_idx, ch_acc[c].wdata}, {a[3:0], 8'(i)});
               end
            end
         join
      end
      ch_report <= '0;
      wr(OFS_BROADCAST, 8'h00);
      // Self-clearing channel soft reset
      wr(OFS_SOFT_RESET, 8'h05);
      #1 cmp_port(16'(ch_soft_reset), 16'h0005);
      @(posedge clock);
      #1 cmp_port(16'(ch_soft_reset), 16'h0000);
      // Sampling rate select and timer count
      r = $random(seed);
      wr(OFS_SAMPLE_RATE, 8'(r));
      #1 cmp_port(16'(ch_sample_8x), 16'(r & 15));
      wr(OFS_TIMER_LOW, 8'h34);
      wr(OFS_TIMER_HIGH, 8'h12);
      #1 cmp_port(timer_count, 16'h1234);
      // Timer masked by its own command, then enabled and cleared by reading
      wr(OFS_TIMER_CMD, {4'h0, TCMD_IRQ_OFF});
      pulse(1'b1);
      rd(OFS_SRC_LOW, RST_ZERO);
      wr(OFS_TIMER_CMD, 8'h00);
      // Masked time-out still reads as pending; the read clears it
      rd(OFS_TIMER_CMD, TIMER_PEND_READ);
      rd(OFS_TIMER_CMD, RST_ZERO);
      fork
         wr(OFS_TIMER_CMD, {4'h0, TCMD_IRQ_ON});
         begin
            @(posedge clock);
            @(negedge clock);
            cmp_port({timer_cmd_stb, timer_cmd}, {1'b1, TCMD_IRQ_ON});
         end
      join
      pulse(1'b1);
      rd(OFS_SRC_LOW, {5'h00, SRC_TIMER});
      rd(OFS_TIMER_CMD, TIMER_PEND_READ);
      rd(OFS_TIMER_CMD, RST_ZERO);
      rd(OFS_SRC_LOW, RST_ZERO);
      // Wake reported only when every channel slept
      wr(OFS_SLEEP_EN, 8'h07);
      #1 cmp_port(16'(ch_sleep_en), 16'h0007);
      pulse(1'b0);
      rd(OFS_PENDING_MAP, RST_ZERO);
      wr(OFS_SLEEP_EN, 8'h0F);
      pulse(1'b0);
      rd(OFS_PENDING_MAP, 8'h01);
      rd(OFS_SLEEP_EN, 8'h0F);
      rd(OFS_PENDING_MAP, RST_ZERO);
      // Mid-run reset with every channel requesting clears the whole block
      ch_report <= {4{1'b1, SRC_RX_LINE}};
      rd(OFS_PENDING_MAP, 8'h0F);
      rst_n <= 1'b0;
      ch_report <= '0;
      @(posedge clock);
      #1 cmp_port({irq, ch_sample_8x, ch_sleep_en}, 16'h0000);
      @(posedge clock);
      rst_n <= 1'b1;
      rd(OFS_PENDING_MAP, RST_ZERO);
      rd(OFS_SRC_LOW, RST_ZERO);
      tally_and_finish();
   end
endmodule
